// file: src/pbc_pkg.sv
// Notes on behaviour
// - port b direction 0 input, 1 drive; reset 0
// - port b open-drain bit picks open-drain driver
// - port b lines 15, 14, 12 lack open-drain
// - port b data bit 14 drives no pin
// - alternate inputs read the sampled pin latch
// - alternate output pin drives latch AND signal
// - idle alternate output rests high
// - alternate outputs: timer6, timer3, transmit, clock
// - clock output forces line 15 driver on
// - strap picks strobe; disable frees it unless config set
// - strobe forces line 12 driver on
// - bus hold returns line 12 to port
// - port c direction 0 input; low byte resets 0
// - port c open-drain only bits 6, 7
// - open-drain on port c skipped for segment lines
// - segment select strapped at reset, read back
// - segment lines take port c after reset
// - select codes 01 none, 11 two, 00 four, 10 eight
// - non-full segment leaves upper lines to can
package pbc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] PB_OD_ADDR = 16'hF1C6;
  localparam logic [15:0] PC_OD_ADDR = 16'hF1CA;
  localparam logic [15:0] PB_DATA_ADDR = 16'hFFC4;
  localparam logic [15:0] PB_DIR_ADDR = 16'hFFC6;
  localparam logic [15:0] PC_DATA_ADDR = 16'hFFC8;
  localparam logic [15:0] PC_DIR_ADDR = 16'hFFCA;
  localparam logic [15:0] ALT_CTRL_ADDR = 16'hF1D0;
  localparam logic [15:0] CFG_RB_ADDR = 16'hF1D2;

  // ---------------------------------------------------------------
  // reset values and implemented-bit masks
  // ---------------------------------------------------------------
  localparam logic [15:0] PB_DATA_RST = 16'h0000;
  localparam logic [15:0] PB_DIR_RST = 16'h0000;
  localparam logic [15:0] PB_OD_RST = 16'h0000;
  localparam logic [7:0] PC_DATA_RST = 8'h00;
  localparam logic [7:0] PC_DIR_RST = 8'h00;
  localparam logic [7:0] PC_OD_RST = 8'h00;
  localparam logic SYSTEM_CLOCK_OUTPUT_EN_RST = 1'b0;
  localparam logic [15:0] PB_OD_MASK = 16'h2FFF;
  localparam logic [7:0] PC_OD_MASK = 8'hC0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PB_T6_LINE = 1;
  localparam int PB_T3_LINE = 3;
  localparam int PB_TX_LINE = 10;
  localparam int PB_STROBE_LINE = 12;
  localparam int PB_NOPIN_LINE = 14;
  localparam int PB_CLK_LINE = 15;
  localparam int PC_CANA_TX_LINE = 6;
  localparam int PC_CANB_TX_LINE = 7;
  localparam int ACTL_SYSTEM_CLOCK_OUTPUT_BIT = 0;
  localparam int ACTL_BYTE_STROBE_DISABLE_BIT = 1;
  localparam int ACTL_WRITE_CONFIG_BIT = 2;

  // segment line select codes
  localparam logic [1:0] SEG_NONE = 2'b01;
  localparam logic [1:0] SEG_TWO = 2'b11;
  localparam logic [1:0] SEG_FOUR = 2'b00;
  localparam logic [1:0] SEG_EIGHT = 2'b10;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } pbc_bus_s;

  typedef struct packed {
    logic [1:0] segment_line_select;
    logic byte_strobe_disable;
    logic write_config;
  } pbc_strap_s;

  typedef struct packed {
    logic timer6_toggle_out;
    logic timer6_en;
    logic timer3_toggle_out;
    logic timer3_en;
    logic async_transmit;
    logic async_tx_en;
    logic system_clock_output;
    logic byte_high_strobe;
    logic write_high_strobe;
    logic bus_hold;
    logic can_ctrl_a_transmit;
    logic can_a_en;
    logic can_ctrl_b_transmit;
    logic can_b_en;
    logic [7:0] seg_addr;
  } pbc_alt_out_s;

  typedef struct packed {
    logic capture_timer0_count_in;
    logic gp_timer_capture_in;
    logic timer3_updown_in;
    logic timer4_count_in;
    logic timer3_count_in;
    logic timer2_count_in;
    logic sync_master_in_slave_out;
    logic sync_master_out_slave_in;
    logic async_receive;
    logic sync_clock_in;
    logic can_ctrl_b_receive;
    logic can_ctrl_a_receive;
  } pbc_alt_in_s;

  typedef struct packed {
    logic [15:0] pb_data;
    logic [15:0] pb_dir;
    logic [15:0] pb_od;
    logic [7:0] pc_data;
    logic [7:0] pc_dir;
    logic [7:0] pc_od;
    logic system_clock_output_en;
    logic byte_strobe_disable;
    logic write_config;
    logic [1:0] segment_line_select;
    logic [15:0] pb_s1;
    logic [15:0] pb_s2;
    logic [15:0] pb_s3;
    logic [15:0] pb_filt;
    logic [7:0] pc_s1;
    logic [7:0] pc_s2;
    logic [7:0] pc_s3;
    logic [7:0] pc_filt;
    logic [3:0] st_s1;
    logic [3:0] st_s2;
    logic [3:0] st_s3;
    logic [3:0] st_filt;
    logic [15:0] pb_out;
    logic [15:0] pb_oe;
    logic [7:0] pc_out;
    logic [7:0] pc_oe;
    logic [15:0] rdata;
  } pbc_state_s;

endpackage : pbc_pkg

// file: src/pbc_ports.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_ports
  import pbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pbc_bus_s bus_i,
  output logic [15:0] rdata_o,
  input wire logic [15:0] pb_pin_i,
  output logic [15:0] pb_pin_o,
  output logic [15:0] pb_pin_oe_o,
  input wire logic [7:0] pc_pin_i,
  output logic [7:0] pc_pin_o,
  output logic [7:0] pc_pin_oe_o,
  input wire pbc_strap_s low_data_port_i,
  input wire pbc_alt_out_s alt_i,
  output var pbc_alt_in_s alt_in_o
);

  pbc_state_s st_reg;
  pbc_state_s st_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a bit moves only once stages two and three agree
  function automatic logic [15:0] settle(input logic [15:0] s2,
                                         input logic [15:0] s3,
                                         input logic [15:0] f);
    logic [15:0] agree;
    agree = ~(s2 ^ s3);
    settle = (s3 & agree) | (f & ~agree);
  endfunction : settle

  // {oe, out}: open drain only ever pulls low
  function automatic logic [1:0] pin_drive(input logic v,
                                           input logic dir,
                                           input logic od);
    pin_drive = od ? {dir & ~v, 1'b0} : {dir, v};
  endfunction : pin_drive

  function automatic logic [7:0] seg_mask(input logic [1:0] sel);
    logic [7:0] m;
    m = 8'h00;
    if (sel == SEG_TWO) begin
      m = 8'h03;
    end else if (sel == SEG_FOUR) begin
      m = 8'h0F;
    end else if (sel == SEG_EIGHT) begin
      m = 8'hFF;
    end
    seg_mask = m;
  endfunction : seg_mask

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [15:0] pb_alt;
  logic [7:0] pc_alt;
  logic [7:0] pc_seg;
  logic [1:0] drv;
  logic strobe_on;
  logic strobe_val;
  logic [15:0] rd;
  // the shared settle helper is 16 wide; narrower samplers are cut back after it
  logic [15:0] pc_wide;
  logic [15:0] st_wide;

  always_comb begin
    st_next = st_reg;
    // three-stage sampling of pins and straps
    st_next.pb_s1 = pb_pin_i;
    st_next.pb_s2 = st_reg.pb_s1;
    st_next.pb_s3 = st_reg.pb_s2;
    st_next.pb_filt = settle(st_reg.pb_s2, st_reg.pb_s3, st_reg.pb_filt);
    st_next.pc_s1 = pc_pin_i;
    st_next.pc_s2 = st_reg.pc_s1;
    st_next.pc_s3 = st_reg.pc_s2;
    pc_wide = settle({8'h00, st_reg.pc_s2}, {8'h00, st_reg.pc_s3},
                     {8'h00, st_reg.pc_filt});
    st_next.pc_filt = pc_wide[7:0];
    st_next.st_s1 = low_data_port_i;
    st_next.st_s2 = st_reg.st_s1;
    st_next.st_s3 = st_reg.st_s2;
    st_wide = settle({12'h000, st_reg.st_s2}, {12'h000, st_reg.st_s3},
                     {12'h000, st_reg.st_filt});
    st_next.st_filt = st_wide[3:0];

    // register writes; unmapped addresses are ignored
    if (bus_i.we) begin
      if (bus_i.addr == PB_DATA_ADDR) begin
        st_next.pb_data = bus_i.wdata;
      end else if (bus_i.addr == PB_DIR_ADDR) begin
        st_next.pb_dir = bus_i.wdata;
      end else if (bus_i.addr == PB_OD_ADDR) begin
        st_next.pb_od = bus_i.wdata & PB_OD_MASK;
      end else if (bus_i.addr == PC_DATA_ADDR) begin
        st_next.pc_data = bus_i.wdata[7:0];
      end else if (bus_i.addr == PC_DIR_ADDR) begin
        st_next.pc_dir = bus_i.wdata[7:0];
      end else if (bus_i.addr == PC_OD_ADDR) begin
        st_next.pc_od = bus_i.wdata[7:0] & PC_OD_MASK;
      end else if (bus_i.addr == ALT_CTRL_ADDR) begin
        st_next.system_clock_output_en = bus_i.wdata[ACTL_SYSTEM_CLOCK_OUTPUT_BIT];
        st_next.byte_strobe_disable = bus_i.wdata[ACTL_BYTE_STROBE_DISABLE_BIT];
        st_next.write_config = bus_i.wdata[ACTL_WRITE_CONFIG_BIT];
      end
    end

    // idle alternate outputs sit high so the latch passes through
    pb_alt = 16'hFFFF;
    pb_alt[PB_T6_LINE] = alt_i.timer6_en ? alt_i.timer6_toggle_out : 1'b1;
    pb_alt[PB_T3_LINE] = alt_i.timer3_en ? alt_i.timer3_toggle_out : 1'b1;
    pb_alt[PB_TX_LINE] = alt_i.async_tx_en ? alt_i.async_transmit : 1'b1;
    pb_alt[PB_CLK_LINE] = st_reg.system_clock_output_en ? alt_i.system_clock_output : 1'b1;

    // write-high strobe when configured, else byte-high unless disabled
    strobe_on = st_reg.write_config | ~st_reg.byte_strobe_disable;
    strobe_val = st_reg.write_config ? alt_i.write_high_strobe
                                     : alt_i.byte_high_strobe;

    // port b pin drivers
    for (int i = 0; i < 16; i++) begin
      drv = pin_drive(st_reg.pb_data[i] & pb_alt[i], st_reg.pb_dir[i],
                      st_reg.pb_od[i]);
      st_next.pb_oe[i] = drv[1];
      st_next.pb_out[i] = drv[0];
    end
    if (st_reg.system_clock_output_en) begin
      st_next.pb_oe[PB_CLK_LINE] = 1'b1;
    end
    // hold hands the strobe line back to plain port control
    if (strobe_on && !alt_i.bus_hold) begin
      st_next.pb_oe[PB_STROBE_LINE] = 1'b1;
      st_next.pb_out[PB_STROBE_LINE] = strobe_val;
    end
    st_next.pb_oe[PB_NOPIN_LINE] = 1'b0;
    st_next.pb_out[PB_NOPIN_LINE] = 1'b0;

    // port c: segment lines first, can transmit on the upper pair
    pc_seg = seg_mask(st_reg.segment_line_select);
    pc_alt = 8'hFF;
    if (st_reg.segment_line_select != SEG_EIGHT) begin
      pc_alt[PC_CANA_TX_LINE] = alt_i.can_a_en ? alt_i.can_ctrl_a_transmit : 1'b1;
      pc_alt[PC_CANB_TX_LINE] = alt_i.can_b_en ? alt_i.can_ctrl_b_transmit : 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      drv = pin_drive(st_reg.pc_data[i] & pc_alt[i], st_reg.pc_dir[i],
                      st_reg.pc_od[i] & ~pc_seg[i]);
      st_next.pc_oe[i] = drv[1];
      st_next.pc_out[i] = drv[0];
      if (pc_seg[i]) begin
        st_next.pc_oe[i] = 1'b1;
        st_next.pc_out[i] = alt_i.seg_addr[i];
      end
    end

    // read data stands only in the cycle after the strobe
    rd = 16'h0000;
    if (bus_i.re) begin
      if (bus_i.addr == PB_DATA_ADDR) begin
        rd = (st_reg.pb_dir & st_reg.pb_data) | (~st_reg.pb_dir & st_reg.pb_filt);
        rd[PB_NOPIN_LINE] = st_reg.pb_data[PB_NOPIN_LINE];
      end else if (bus_i.addr == PB_DIR_ADDR) begin
        rd = st_reg.pb_dir;
      end else if (bus_i.addr == PB_OD_ADDR) begin
        rd = st_reg.pb_od;
      end else if (bus_i.addr == PC_DATA_ADDR) begin
        rd = {8'h00, (st_reg.pc_dir & st_reg.pc_data) |
                     (~st_reg.pc_dir & st_reg.pc_filt)};
      end else if (bus_i.addr == PC_DIR_ADDR) begin
        rd = {8'h00, st_reg.pc_dir};
      end else if (bus_i.addr == PC_OD_ADDR) begin
        rd = {8'h00, st_reg.pc_od};
      end else if (bus_i.addr == ALT_CTRL_ADDR) begin
        rd[ACTL_SYSTEM_CLOCK_OUTPUT_BIT] = st_reg.system_clock_output_en;
        rd[ACTL_BYTE_STROBE_DISABLE_BIT] = st_reg.byte_strobe_disable;
        rd[ACTL_WRITE_CONFIG_BIT] = st_reg.write_config;
      end else if (bus_i.addr == CFG_RB_ADDR) begin
        rd[1:0] = st_reg.segment_line_select;
      end
    end
    st_next.rdata = rd;

    // reset: straps are taken from the settled sampler every cycle of it,
    // so reset must last past the sampler depth
    if (rst_i) begin
      st_next.pb_data = PB_DATA_RST;
      st_next.pb_dir = PB_DIR_RST;
      st_next.pb_od = PB_OD_RST;
      st_next.pc_data = PC_DATA_RST;
      st_next.pc_dir = PC_DIR_RST;
      st_next.pc_od = PC_OD_RST;
      st_next.system_clock_output_en = SYSTEM_CLOCK_OUTPUT_EN_RST;
      st_next.segment_line_select = st_reg.st_filt[3:2];
      st_next.byte_strobe_disable = st_reg.st_filt[1];
      st_next.write_config = st_reg.st_filt[0];
      st_next.pb_out = 16'h0000;
      st_next.pb_oe = 16'h0000;
      st_next.pc_out = 8'h00;
      st_next.pc_oe = 8'h00;
      st_next.rdata = 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  // outputs straight from flops
  assign rdata_o = st_reg.rdata;
  assign pb_pin_o = st_reg.pb_out;
  assign pb_pin_oe_o = st_reg.pb_oe;
  assign pc_pin_o = st_reg.pc_out;
  assign pc_pin_oe_o = st_reg.pc_oe;

  // peripherals read the settled pin latch
  assign alt_in_o.capture_timer0_count_in = st_reg.pb_filt[0];
  assign alt_in_o.gp_timer_capture_in = st_reg.pb_filt[2];
  assign alt_in_o.timer3_updown_in = st_reg.pb_filt[4];
  assign alt_in_o.timer4_count_in = st_reg.pb_filt[5];
  assign alt_in_o.timer3_count_in = st_reg.pb_filt[6];
  assign alt_in_o.timer2_count_in = st_reg.pb_filt[7];
  assign alt_in_o.sync_master_in_slave_out = st_reg.pb_filt[8];
  assign alt_in_o.sync_master_out_slave_in = st_reg.pb_filt[9];
  assign alt_in_o.async_receive = st_reg.pb_filt[11];
  assign alt_in_o.sync_clock_in = st_reg.pb_filt[13];
  assign alt_in_o.can_ctrl_b_receive = st_reg.pc_filt[4];
  assign alt_in_o.can_ctrl_a_receive = st_reg.pc_filt[5];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence od_b_read;
    bus_i.re && bus_i.addr == PB_OD_ADDR;
  endsequence
  sequence od_c_read;
    bus_i.re && bus_i.addr == PC_OD_ADDR;
  endsequence
  sequence settled;
    !$past(rst_i) ##0 1'b1;
  endsequence

  nopin_line_a: assert property (!pb_pin_oe_o[14] && !pb_pin_o[14])
    else $error("line 14 driven");
  od_b_bits_a: assert property (od_b_read |=> rdata_o[15:14] == 2'b00 && !rdata_o[12])
    else $error("port b open-drain reserved bits set");
  od_c_bits_a: assert property (od_c_read |=> rdata_o[15:8] == 8'h00 &&
                                rdata_o[5:0] == 6'h00)
    else $error("port c open-drain reserved bits set");
  dir_input_a: assert property (settled ##0 !$past(st_reg.pb_dir[0]) |-> !pb_pin_oe_o[0])
    else $error("input line driven");
  system_clock_output_force_a: assert property (settled ##0 $past(st_reg.system_clock_output_en) |-> pb_pin_oe_o[15])
    else $error("clock output driver off");
  alt_and_a: assert property (settled ##0 $past(st_reg.pb_dir[3] && !st_reg.pb_od[3])
      |-> pb_pin_o[3] == $past(st_reg.pb_data[3] & (alt_i.timer3_toggle_out | !alt_i.timer3_en)))
    else $error("timer 3 pin not latch and output");
  strobe_force_a: assert property (settled ##0
      $past((st_reg.write_config | ~st_reg.byte_strobe_disable) & ~alt_i.bus_hold)
      |-> pb_pin_oe_o[12])
    else $error("strobe driver off");
  hold_plain_a: assert property (settled ##0 $past(alt_i.bus_hold)
      |-> pb_pin_oe_o[12] == $past(st_reg.pb_dir[12]))
    else $error("line 12 not under port control in hold");
  seg_full_a: assert property (settled ##0 $past(st_reg.segment_line_select) == SEG_EIGHT
      |-> pc_pin_oe_o == 8'hFF)
    else $error("segment lines not driven");
  seg_none_a: assert property (settled ##0 $past(st_reg.segment_line_select == SEG_NONE &&
      st_reg.pc_dir[0] == 1'b0) |-> !pc_pin_oe_o[0])
    else $error("port c line 0 driven without segment");
  // judged bit by bit: other lines may still be moving through the sampler
  filter_agree_a: assert property ($changed(st_reg.pb_filt) |->
      ((st_reg.pb_filt ^ $past(st_reg.pb_filt)) & $past(st_reg.pb_s2 ^ st_reg.pb_s3)) == 16'h0000)
    else $error("pin latch moved before stages agreed");
  seg_rb_a: assert property (bus_i.re && bus_i.addr == CFG_RB_ADDR
      |=> rdata_o[1:0] == $past(st_reg.segment_line_select))
    else $error("segment select readback wrong");

endmodule : pbc_ports
`default_nettype wire

// file: verif/pbc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// board side: pull-ups plus optional external drivers
// ---------------------------------------------------------------
module pbc_pin_model (
  input wire logic [15:0] pb_out_i,
  input wire logic [15:0] pb_oe_i,
  input wire logic [15:0] pb_ext_i,
  input wire logic [15:0] pb_ext_en_i,
  input wire logic [7:0] pc_out_i,
  input wire logic [7:0] pc_oe_i,
  input wire logic [7:0] pc_ext_i,
  input wire logic [7:0] pc_ext_en_i,
  output logic [15:0] pb_lvl_o,
  output logic [7:0] pc_lvl_o
);
  // a released or open-drain high line floats up to 1 through its pull-up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pb_lvl_o[i] = pb_oe_i[i] ? pb_out_i[i] : (pb_ext_en_i[i] ? pb_ext_i[i] : 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      pc_lvl_o[i] = pc_oe_i[i] ? pc_out_i[i] : (pc_ext_en_i[i] ? pc_ext_i[i] : 1'b1);
    end
  end
endmodule : pbc_pin_model
`default_nettype wire

// file: verif/port3_port4_gpio_altfunc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module port3_port4_gpio_altfunc_tb_top;
  import pbc_pkg::*;
  // ---------------------------------------------------------------
  // signals and tables
  // ---------------------------------------------------------------
  localparam logic [15:0] PAT = 16'h5A3C;
  logic clk, rst;
  pbc_bus_s bus;
  pbc_strap_s strap;
  pbc_alt_out_s alt;
  pbc_alt_in_s alt_in;
  logic [15:0] rdata, pb_o, pb_oe, pb_lvl, pb_ext, pb_ext_en;
  logic [7:0] pc_o, pc_oe, pc_lvl, pc_ext, pc_ext_en;
  logic [15:0] exp_pb, exp_rd;
  logic [7:0] exp_pc;
  int n_mismatch, n_checks;
  logic [1:0] codes [4] = '{SEG_NONE, SEG_TWO, SEG_EIGHT, SEG_FOUR};
  logic [7:0] segm [4] = '{8'h00, 8'h03, 8'hFF, 8'h0F};
  logic [15:0] addrs [6] = '{PB_OD_ADDR, PC_OD_ADDR, PB_DATA_ADDR, PB_DIR_ADDR,
                             PC_DATA_ADDR, PC_DIR_ADDR};
  int lines [4] = '{1, 3, 10, 15};

  always #10 clk = ~clk;

  pbc_ports dut (.clk_i(clk), .rst_i(rst), .bus_i(bus), .rdata_o(rdata),
    .pb_pin_i(pb_lvl), .pb_pin_o(pb_o), .pb_pin_oe_o(pb_oe), .pc_pin_i(pc_lvl),
    .pc_pin_o(pc_o), .pc_pin_oe_o(pc_oe), .low_data_port_i(strap), .alt_i(alt),
    .alt_in_o(alt_in));

  pbc_pin_model pins (.pb_out_i(pb_o), .pb_oe_i(pb_oe), .pb_ext_i(pb_ext),
    .pb_ext_en_i(pb_ext_en), .pc_out_i(pc_o), .pc_oe_i(pc_oe), .pc_ext_i(pc_ext),
    .pc_ext_en_i(pc_ext_en), .pb_lvl_o(pb_lvl), .pc_lvl_o(pc_lvl));

  // ---------------------------------------------------------------
  // bus cycles and comparison
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge clk);
    bus.we <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input logic [15:0] a, input logic [15:0] want, input string name);
    @(posedge clk);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge clk);
    bus.re <= 1'b0;
    #1;
    check(name, rdata, want);
  endtask : rchk

  // pin inputs go through three flops, so allow a few edges
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic reset_dut(input logic [1:0] sel, input logic bd, input logic wc);
    @(posedge clk);
    strap <= '{segment_line_select: sel, byte_strobe_disable: bd, write_config: wc};
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask : reset_dut

  task automatic set_alt(input int i, input logic v);
    @(posedge clk);
    case (i)
      0: begin
        alt.timer6_en <= 1'b1;
        alt.timer6_toggle_out <= v;
      end
      1: begin
        alt.timer3_en <= 1'b1;
        alt.timer3_toggle_out <= v;
      end
      2: begin
        alt.async_tx_en <= 1'b1;
        alt.async_transmit <= v;
      end
      default: alt.system_clock_output <= v;
    endcase
  endtask : set_alt

  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    bus = '0;
    strap = '0;
    alt = '0;
    alt.byte_high_strobe = 1'b1;
    alt.seg_addr = 8'hA5;
    pb_ext = '0;
    pb_ext_en = '0;
    pc_ext = '0;
    pc_ext_en = '0;
    // every segment code, with the strobe straps varied alongside
    for (int k = 0; k < 4; k++) begin
      reset_dut(codes[k], (k != 3), (k == 1));
      settle();
      // data reads of input lines show the pins: pull-ups, segment lines, a low strobe
      exp_pb = 16'hBFFF & ~{3'h0, (k == 1), 12'h000};
      exp_pc = (8'hA5 & segm[k]) | ~segm[k];
      for (int a = 0; a < 6; a++) begin
        exp_rd = (addrs[a] == PB_DATA_ADDR) ? exp_pb : 16'h0000;
        if (addrs[a] == PC_DATA_ADDR) begin
          exp_rd = {8'h00, exp_pc};
        end
        rchk(addrs[a], exp_rd, "reg_reset");
      end
      rchk(ALT_CTRL_ADDR, {13'h0, (k == 1), (k != 3), 1'b0}, "alt_ctrl");
      rchk(CFG_RB_ADDR, {14'h0, codes[k]}, "seg_select");
      check("pc_oe", {8'h00, pc_oe}, {8'h00, segm[k]});
      check("pc_out", {8'h00, pc_o}, {8'h00, segm[k] & 8'hA5});
      check("strobe_oe", {15'h0, pb_oe[12]}, {15'h0, k[0]});
      check("strobe_out", {15'h0, pb_o[12]}, {15'h0, (k == 3)});
      if (k == 2) begin
        wr(PC_OD_ADDR, 16'hFFFF);
        rchk(PC_OD_ADDR, 16'h00C0, "pc_od");
        settle();
        check("seg_pp", {pc_oe, pc_o}, 16'hFFA5);
      end
    end
    // bus hold hands line 12 back to its direction bit, kept at 0 here
    @(posedge clk);
    alt.bus_hold <= 1'b1;
    settle();
    check("hold_oe", {15'h0, pb_oe[12]}, 16'h0000);
    @(posedge clk);
    alt.bus_hold <= 1'b0;
    settle();
    check("strobe_back", {15'h0, pb_oe[12]}, 16'h0001);
    wr(ALT_CTRL_ADDR, 16'h0002);
    settle();
    check("strobe_free", {15'h0, pb_oe[12]}, 16'h0000);
    // push-pull and open-drain mix on port b
    wr(PB_DIR_ADDR, 16'hFFFF);
    wr(PB_DATA_ADDR, 16'hF0F0);
    wr(PB_OD_ADDR, 16'hFFFF);
    rchk(PB_OD_ADDR, 16'h2FFF, "pb_od");
    rchk(PB_DATA_ADDR, 16'hF0F0, "pb_latch");
    settle();
    check("pb_oe", pb_oe, (16'hD000 | 16'h0F0F) & 16'hBFFF);
    check("pb_out", pb_o & 16'hBFFF, 16'hF0F0 & 16'hD000 & 16'hBFFF);
    // alternate outputs: direction and latch set first
    wr(PB_OD_ADDR, 16'h0000);
    wr(PB_DATA_ADDR, 16'hFFFF);
    settle();
    check("alt_idle", pb_o & 16'hBFFF, 16'hBFFF);
    wr(ALT_CTRL_ADDR, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      set_alt(i, 1'b0);
      settle();
      check("alt_low", {15'h0, pb_o[lines[i]]}, 16'h0000);
      set_alt(i, 1'b1);
      settle();
      check("alt_high", {15'h0, pb_o[lines[i]]}, 16'h0001);
    end
    wr(PB_DATA_ADDR, 16'hFFFD);
    settle();
    check("alt_and", {15'h0, pb_o[1]}, 16'h0000);
    wr(PB_DIR_ADDR, 16'h0000);
    settle();
    check("clk_drv", pb_oe, 16'h8000);
    // inputs: pins driven from the board, can lines on port c
    wr(ALT_CTRL_ADDR, 16'h0002);
    wr(PC_DIR_ADDR, 16'h00C0);
    wr(PC_DATA_ADDR, 16'h00C0);
    @(posedge clk);
    alt.can_a_en <= 1'b1;
    alt.can_b_en <= 1'b1;
    alt.can_ctrl_a_transmit <= 1'b1;
    pb_ext <= PAT;
    pb_ext_en <= 16'hFFFF;
    pc_ext <= 8'h20;
    pc_ext_en <= 8'h30;
    repeat (8) @(posedge clk);
    #1;
    check("can_tx", {8'h00, pc_o & 8'hC0}, 16'h0040);
    check("alt_in", {4'h0, alt_in}, {4'h0, PAT[0], PAT[2], PAT[4], PAT[5], PAT[6],
      PAT[7], PAT[8], PAT[9], PAT[11], PAT[13], 1'b0, 1'b1});
    rchk(PB_DATA_ADDR, (PAT & 16'hBFFF) | 16'h4000, "pb_read");
    rchk(PC_DATA_ADDR, 16'h00E5, "pc_read");
    rchk(16'hF1D4, 16'h0000, "unmapped");
    wr(CFG_RB_ADDR, 16'hFFFF);
    rchk(CFG_RB_ADDR, {14'h0, SEG_FOUR}, "seg_ro");
    stop_test();
  end

  // watchdog: the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule : port3_port4_gpio_altfunc_tb_top
`default_nettype wire
